// ==== core/tpucfg_defines.svh ====
`ifndef TPUCFG_DEFINES_SVH
`define TPUCFG_DEFINES_SVH
// register word indices; byte address is four times the index
`define TPUCFG_MODE_IDX 6'h00
`define TPUCFG_IOC_IDX 6'h08
`define TPUCFG_CKS_IDX 6'h10
`define TPUCFG_START_IDX 6'h14
// mode register layout
`define TPUCFG_MODE_RSV_ONES 2'b11
`define TPUCFG_BFB_BIT 5
`define TPUCFG_BFA_BIT 4
`define TPUCFG_MODE_RST 6'h00
`define TPUCFG_IOC_RST 8'h00
`define TPUCFG_CKS_RST 3'h0
`define TPUCFG_START_RST 6'h00
// prescaler width and tap positions (divide by 4**tap)
`define TPUCFG_PRE_W 12
`define TPUCFG_TAP_1 0
`define TPUCFG_TAP_4 1
`define TPUCFG_TAP_16 2
`define TPUCFG_TAP_64 3
`define TPUCFG_TAP_256 4
`define TPUCFG_TAP_1024 5
`define TPUCFG_TAP_4096 6
`define TPUCFG_N_TAP 7
// bus answers
`define TPUCFG_RESP_OKAY 2'b00
`define TPUCFG_RESP_SLVERR 2'b10
`endif

// ==== core/tpucfg_pkg.sv ====
package tpucfg_pkg;
   // decoded channel operating mode
   typedef enum logic [3:0] {
      MODE_NORMAL, MODE_RESERVED, MODE_PWM1, MODE_PWM2,
      MODE_PHASE1, MODE_PHASE2, MODE_PHASE3, MODE_PHASE4, MODE_UNDEF
   } tpucfg_mode_t;

   function automatic tpucfg_mode_t tpucfg_decode(input logic [3:0] md);
      tpucfg_mode_t m;
      m = MODE_UNDEF;
      case (md)
         4'h0: m = MODE_NORMAL;
         4'h1: m = MODE_RESERVED;
         4'h2: m = MODE_PWM1;
         4'h3: m = MODE_PWM2;
         4'h4: m = MODE_PHASE1;
         4'h5: m = MODE_PHASE2;
         4'h6: m = MODE_PHASE3;
         4'h7: m = MODE_PHASE4;
         default: m = MODE_UNDEF;
      endcase
      return m;
   endfunction : tpucfg_decode
endpackage : tpucfg_pkg

// ==== core/tpucfg_top.sv ====
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tpucfg_defines.svh"
module tpucfg_top #(
   parameter int PRE_W = `TPUCFG_PRE_W
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic ext_count_pin_a,
   input wire logic ext_count_pin_c,
   input wire logic ext_count_pin_d,
   input wire logic channel5_wrap,
   input wire logic [1:0] phase_tick,
   input wire logic [5:0] counter_clear,
   output logic [2:0] count_tick,
   output logic [5:0] phase_mode,
   output logic [5:0] pwm_mode,
   output logic [1:0] gen_c_active,
   output logic [1:0] gen_d_active,
   output logic [5:0] cmp_pin_a,
   output logic [5:0] cmp_pin_b,
   output logic [1:0] cmp_pin_c,
   output logic [1:0] cmp_pin_d
);
   logic [5:0] mode_reg [6];
   logic [7:0] ioc_reg [8];
   logic [2:0] cks_reg [3];
   logic [5:0] start_reg;
   logic [PRE_W-1:0] pre_reg;
   logic aw_got_reg, w_got_reg, wstrb0_reg;
   logic [5:0] wa_reg;
   logic [7:0] wd_reg;
   logic do_wr;
   logic [7:0] rd_word;
   logic rd_hit, wr_hit;
   logic [`TPUCFG_N_TAP-1:0] tap;
   logic [2:0] ext_prev_reg;
   logic [2:0] ext_rise;
   logic [2:0] src;
   logic [5:0] phase_c, pwm1_c, pwm2_c;
   logic [5:0] pin_ld;

   // channels 0 and 3 own general registers c and d
   function automatic logic has_cd(input int i);
      return (i == 0) || (i == 3);
   endfunction : has_cd

   // io control register holding a/b of a channel
   function automatic int ioc_hi(input int i);
      return (i < 3) ? ((i == 0) ? 0 : i + 1) : ((i == 3) ? 4 : i + 2);
   endfunction : ioc_hi

   // loads the initial level when asked and the nibble selects an output
   function automatic logic pin_upd(input logic cur, input logic [3:0] f, input logic load);
      return (load && !f[3] && (f[1:0] != 2'b00)) ? f[2] : cur;
   endfunction : pin_upd

   // word index decode shared by reads and writes
   function automatic logic is_mapped(input logic [5:0] a);
      return (a < 6'(`TPUCFG_MODE_IDX + 6)) || ((a >= `TPUCFG_IOC_IDX) && (a < 6'(`TPUCFG_IOC_IDX + 8)))
         || ((a >= `TPUCFG_CKS_IDX) && (a < 6'(`TPUCFG_CKS_IDX + 3))) || (a == `TPUCFG_START_IDX);
   endfunction : is_mapped

   // write address and data are taken independently, the write waits for both
   assign do_wr = aw_got_reg && w_got_reg && !s_axi_bvalid;
   assign wr_hit = is_mapped(wa_reg);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_reg <= 1'b0;
         s_axi_awready <= 1'b0;
         wa_reg <= 6'h00;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_got_reg <= 1'b1;
         s_axi_awready <= 1'b0;
         wa_reg <= s_axi_awaddr[7:2];
      end
      else if (do_wr)
         aw_got_reg <= 1'b0;
      else if (!aw_got_reg)
         s_axi_awready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_got_reg <= 1'b0;
         s_axi_wready <= 1'b0;
         wd_reg <= 8'h00;
         wstrb0_reg <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_got_reg <= 1'b1;
         s_axi_wready <= 1'b0;
         wd_reg <= s_axi_wdata[7:0];
         wstrb0_reg <= s_axi_wstrb[0];
      end
      else if (do_wr)
         w_got_reg <= 1'b0;
      else if (!w_got_reg)
         s_axi_wready <= 1'b1;
   end

   // write response; unmapped words answer slverr
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TPUCFG_RESP_OKAY;
      end
      else if (do_wr)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? `TPUCFG_RESP_OKAY : `TPUCFG_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // mode registers; only the low byte lane carries register bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         for (int i = 0; i < 6; i++)
            mode_reg[i] <= `TPUCFG_MODE_RST;
      else if (do_wr && wstrb0_reg)
         for (int i = 0; i < 6; i++)
            if (wa_reg == 6'(`TPUCFG_MODE_IDX + i))
               mode_reg[i] <= has_cd(i) ? wd_reg[5:0] : {2'b00, wd_reg[3:0]};
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         for (int i = 0; i < 8; i++)
            ioc_reg[i] <= `TPUCFG_IOC_RST;
      else if (do_wr && wstrb0_reg)
         for (int i = 0; i < 8; i++)
            if (wa_reg == 6'(`TPUCFG_IOC_IDX + i))
               ioc_reg[i] <= wd_reg;
   end

   // clock selects of channels 3..5 and the counter start bits
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 0; i < 3; i++)
            cks_reg[i] <= `TPUCFG_CKS_RST;
         start_reg <= `TPUCFG_START_RST;
      end
      else if (do_wr && wstrb0_reg)
      begin
         for (int i = 0; i < 3; i++)
            if (wa_reg == 6'(`TPUCFG_CKS_IDX + i))
               cks_reg[i] <= wd_reg[2:0];
         if (wa_reg == `TPUCFG_START_IDX)
            start_reg <= wd_reg[5:0];
      end
   end

   // read mux
   always_comb
   begin
      logic [5:0] a;
      a = s_axi_araddr[7:2];
      rd_word = 8'h00;
      rd_hit = is_mapped(a);
      for (int i = 0; i < 6; i++)
         if (a == 6'(`TPUCFG_MODE_IDX + i))
            rd_word = {`TPUCFG_MODE_RSV_ONES, mode_reg[i]};
      for (int i = 0; i < 8; i++)
         if (a == 6'(`TPUCFG_IOC_IDX + i))
            rd_word = ioc_reg[i];
      for (int i = 0; i < 3; i++)
         if (a == 6'(`TPUCFG_CKS_IDX + i))
            rd_word = {5'h00, cks_reg[i]};
      if (a == `TPUCFG_START_IDX)
         rd_word = {2'b00, start_reg};
   end

   // one read at a time, answered the cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `TPUCFG_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {24'h00_0000, rd_word};
         s_axi_rresp <= rd_hit ? `TPUCFG_RESP_OKAY : `TPUCFG_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
      else if (!s_axi_rvalid)
         s_axi_arready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         pre_reg <= '0;
      else
         pre_reg <= pre_reg + 1'b1;
   end

   // tap k fires once every 4**k cycles, when its low bits are all ones
   always_comb
   begin
      logic [PRE_W-1:0] m;
      m = '0;
      for (int k = 0; k < `TPUCFG_N_TAP; k++)
      begin
         m = PRE_W'((64'h1 << (2 * k)) - 64'h1);
         tap[k] = ((pre_reg & m) == m);
      end
   end

   // pins are synchronous; count on the rising edge only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ext_prev_reg <= 3'h0;
      else
         ext_prev_reg <= {ext_count_pin_d, ext_count_pin_c, ext_count_pin_a};
   end
   assign ext_rise = {ext_count_pin_d, ext_count_pin_c, ext_count_pin_a} & ~ext_prev_reg;

   // count source selection, one table per channel
   always_comb
   begin
      src = 3'h0;
      case (cks_reg[0])
         3'h0: src[0] = tap[`TPUCFG_TAP_1];
         3'h1: src[0] = tap[`TPUCFG_TAP_4];
         3'h2: src[0] = tap[`TPUCFG_TAP_16];
         3'h3: src[0] = tap[`TPUCFG_TAP_64];
         3'h4: src[0] = ext_rise[0];
         3'h5: src[0] = tap[`TPUCFG_TAP_1024];
         3'h6: src[0] = tap[`TPUCFG_TAP_256];
         default: src[0] = tap[`TPUCFG_TAP_4096];
      endcase
      case (cks_reg[1])
         3'h0: src[1] = tap[`TPUCFG_TAP_1];
         3'h1: src[1] = tap[`TPUCFG_TAP_4];
         3'h2: src[1] = tap[`TPUCFG_TAP_16];
         3'h3: src[1] = tap[`TPUCFG_TAP_64];
         3'h4: src[1] = ext_rise[0];
         3'h5: src[1] = ext_rise[1];
         3'h6: src[1] = tap[`TPUCFG_TAP_1024];
         default: src[1] = channel5_wrap;
      endcase
      case (cks_reg[2])
         3'h0: src[2] = tap[`TPUCFG_TAP_1];
         3'h1: src[2] = tap[`TPUCFG_TAP_4];
         3'h2: src[2] = tap[`TPUCFG_TAP_16];
         3'h3: src[2] = tap[`TPUCFG_TAP_64];
         3'h4: src[2] = ext_rise[0];
         3'h5: src[2] = ext_rise[1];
         3'h6: src[2] = tap[`TPUCFG_TAP_256];
         default: src[2] = ext_rise[2];
      endcase
   end

   always_comb
   begin
      tpucfg_pkg::tpucfg_mode_t m;
      m = tpucfg_pkg::MODE_NORMAL;
      for (int i = 0; i < 6; i++)
      begin
         m = tpucfg_pkg::tpucfg_decode(mode_reg[i][3:0]);
         phase_c[i] = m inside {tpucfg_pkg::MODE_PHASE1, tpucfg_pkg::MODE_PHASE2,
            tpucfg_pkg::MODE_PHASE3, tpucfg_pkg::MODE_PHASE4};
         pwm1_c[i] = (m == tpucfg_pkg::MODE_PWM1);
         pwm2_c[i] = (m == tpucfg_pkg::MODE_PWM2);
      end
   end

   // a stopped counter gets no ticks; channel 3 has no phase inputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_tick <= 3'h0;
      else
      begin
         count_tick[0] <= start_reg[3] && src[0];
         count_tick[1] <= start_reg[4] && (phase_c[4] ? phase_tick[0] : src[1]);
         count_tick[2] <= start_reg[5] && (phase_c[5] ? phase_tick[1] : src[2]);
      end
   end

   // decoded mode flags for the counter logic
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phase_mode <= 6'h00;
         pwm_mode <= 6'h00;
      end
      else
      begin
         phase_mode <= phase_c;
         pwm_mode <= pwm1_c | pwm2_c;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         gen_c_active <= 2'b00;
         gen_d_active <= 2'b00;
      end
      else
      begin
         gen_c_active <= {!mode_reg[3][`TPUCFG_BFA_BIT], !mode_reg[0][`TPUCFG_BFA_BIT]};
         gen_d_active <= {!mode_reg[3][`TPUCFG_BFB_BIT], !mode_reg[0][`TPUCFG_BFB_BIT]};
      end
   end

   // per-channel load condition, kept combinational so the pin flops stay non-blocking
   always_comb
   begin
      pin_ld = 6'h00;
      for (int i = 0; i < 6; i++)
         pin_ld[i] = !start_reg[i] || (pwm2_c[i] && counter_clear[i]);
   end

   // compare pin levels; match-driven changes belong to the counter logic
   // and while the counter runs the pin holds its level except at a counter clear in pwm mode 2
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cmp_pin_a <= 6'h00;
         cmp_pin_b <= 6'h00;
         cmp_pin_c <= 2'b00;
         cmp_pin_d <= 2'b00;
      end
      else
         for (int i = 0; i < 6; i++)
         begin
            cmp_pin_a[i] <= pin_upd(cmp_pin_a[i], ioc_reg[ioc_hi(i)][3:0], pin_ld[i]);
            cmp_pin_b[i] <= pin_upd(cmp_pin_b[i], ioc_reg[ioc_hi(i)][7:4], pin_ld[i]);
            if (has_cd(i))
            begin
               cmp_pin_c[i/3] <= pin_upd(cmp_pin_c[i/3], ioc_reg[ioc_hi(i)+1][3:0],
                  pin_ld[i] && !mode_reg[i][`TPUCFG_BFA_BIT]);
               cmp_pin_d[i/3] <= pin_upd(cmp_pin_d[i/3], ioc_reg[ioc_hi(i)+1][7:4],
                  pin_ld[i] && !mode_reg[i][`TPUCFG_BFB_BIT]);
            end
         end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_mode_rsv_ones: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] < 6'h06
      |=> s_axi_rvalid && s_axi_rdata[7:6] == 2'b11)
      else $error("mode read lost reserved ones");
   a_nocd_bits_zero: assert property (do_wr && wstrb0_reg && wa_reg == 6'h01
      |=> mode_reg[1][5:4] == 2'b00 && mode_reg[1][3:0] == $past(wd_reg[3:0]))
      else $error("buffer bits written on channel without c/d");
   a_ch3_div1024: assert property (start_reg[3] && cks_reg[0] == 3'h5 && pre_reg[9:0] == 10'h3ff
      |=> count_tick[0] ##1 !count_tick[0])
      else $error("channel 3 divide 1024 tick wrong");
   a_ch4_wrap: assert property (start_reg[4] && !phase_c[4] && cks_reg[1] == 3'h7
      |=> count_tick[1] == $past(channel5_wrap))
      else $error("channel 4 not counting on channel 5 wrap");
   a_ch5_pin_d: assert property (start_reg[5] && !phase_c[5] && cks_reg[2] == 3'h7
      && ext_count_pin_d && !ext_prev_reg[2] |=> count_tick[2])
      else $error("channel 5 missed pin d edge");
   a_phase_override: assert property (start_reg[4] && phase_c[4]
      |=> count_tick[1] == $past(phase_tick[0]))
      else $error("phase mode did not override clock select");
   a_buf_c_silent: assert property (mode_reg[0][4] |=> !gen_c_active[0])
      else $error("buffered c still active");
   a_buf_d_silent: assert property (mode_reg[3][5] |=> !gen_d_active[1])
      else $error("buffered d still active");
   a_stop_init_lvl: assert property (!start_reg[0] && !ioc_reg[0][3] && ioc_reg[0][1:0] != 2'b00
      |=> cmp_pin_a[0] == $past(ioc_reg[0][2]))
      else $error("stopped pin not at initial level");
   a_pwm2_clear_lvl: assert property (start_reg[1] && pwm2_c[1] && counter_clear[1]
      && !ioc_reg[2][7] && ioc_reg[2][5:4] != 2'b00 |=> cmp_pin_b[1] == $past(ioc_reg[2][6]))
      else $error("pwm 2 clear level wrong");
   a_run_pin_hold: assert property (start_reg[1] && !(pwm2_c[1] && counter_clear[1]) && $stable(start_reg)
      |=> $stable(cmp_pin_a[1]))
      else $error("running pin changed level");
   a_buf_c_ignored: assert property (mode_reg[3][4] |=> $stable(cmp_pin_c[1]))
      else $error("buffered c pin followed io control");
   a_ioc_rw: assert property (do_wr && wstrb0_reg && wa_reg == 6'h0f
      |=> ioc_reg[7] == $past(wd_reg))
      else $error("io control write lost");

   c_write_done: cover property (do_wr ##1 s_axi_bvalid && s_axi_bready);
   c_ch4_phase: cover property (phase_c[4] && start_reg[4] ##1 count_tick[1]);
   c_pwm2_clear: cover property (pwm2_c[1] && counter_clear[1] && start_reg[1]);
   c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == `TPUCFG_RESP_SLVERR);
endmodule : tpucfg_top

// ==== tb/test_tpucfg_top.sv ====
`timescale 1ns/1ps
`include "tpucfg_defines.svh"
module test_tpucfg_top;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic pin_a = 1'b0;
   logic pin_c = 1'b0;
   logic pin_d = 1'b0;
   logic wrap = 1'b0;
   logic [1:0] ph_tick = 2'b00;
   logic [5:0] clr = 6'h00;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, gen_c, gen_d, pin_c_o, pin_d_o;
   logic [31:0] rdata;
   logic [2:0] tick;
   logic [5:0] phase, pwm, pin_a_o, pin_b_o;
   logic [5:0] exp_a = 6'h00;
   logic [5:0] exp_b = 6'h00;
   logic [1:0] exp_c = 2'b00;
   logic [1:0] exp_d = 2'b00;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   integer seed = 32'h01e7;
   // source periods per clock code; pins and wrap are paced so each code gives a distinct count
   int p3[8] = '{1, 4, 16, 64, 2, 1024, 256, 4096};
   int p4[8] = '{1, 4, 16, 64, 2, 8, 1024, 32};
   int p5[8] = '{1, 4, 16, 64, 2, 8, 256, 32};

   // only byte lane 0 carries register bits
   tpucfg_top dut (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid),
      .s_axi_awready(awready),
      .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid),
      .s_axi_wready(wready),
      .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid),
      .s_axi_bready(bready),
      .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid),
      .s_axi_arready(arready),
      .s_axi_rdata(rdata),
      .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid),
      .s_axi_rready(rready),
      .ext_count_pin_a(pin_a),
      .ext_count_pin_c(pin_c),
      .ext_count_pin_d(pin_d),
      .channel5_wrap(wrap),
      .phase_tick(ph_tick),
      .counter_clear(clr),
      .count_tick(tick),
      .phase_mode(phase),
      .pwm_mode(pwm),
      .gen_c_active(gen_c),
      .gen_d_active(gen_d),
      .cmp_pin_a(pin_a_o),
      .cmp_pin_b(pin_b_o),
      .cmp_pin_c(pin_c_o),
      .cmp_pin_d(pin_d_o)
   );

   always #4 aclk = ~aclk;

   // free-running count sources and the hang limit
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      pin_a <= cyc[0];
      pin_c <= cyc[2];
      pin_d <= cyc[4];
      wrap <= (cyc[4:0] == 5'h1f);
      ph_tick <= {cyc[7:0] == 8'h00, cyc[5:0] == 6'h00};
      if (cyc == 90000)
      begin
         err_count++;
         $display("[ERR] %0t timeout", $time);
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_cnt(input int got, input int exp);
      cmp_count++;
      if (got != exp)
      begin
         err_count++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic chk_pins();
      chk_val({16'h0, pin_a_o, pin_b_o, pin_c_o, pin_d_o}, {16'h0, exp_a, exp_b, exp_c, exp_d});
   endtask : chk_pins

   // bus write; address and data offered together, each dropped once taken
   task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] eresp);
      bit aw_ok;
      bit w_ok;
      aw_ok = 0;
      w_ok = 0;
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1)
         begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1)
         begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1)
         @(posedge aclk);
      chk_val({30'h0, bresp}, {30'h0, eresp});
      bready <= 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] eresp);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
         @(posedge aclk);
      while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1)
         @(posedge aclk);
      chk_val(rdata, exp);
      chk_val({30'h0, rresp}, {30'h0, eresp});
      rready <= 1'b0;
   endtask : rd_chk

   // pin level while stopped: only an output code with a set level moves it
   function automatic logic lvl(input logic [3:0] n, input logic old);
      return (!n[3] && n[1:0] != 2'b00) ? n[2] : old;
   endfunction : lvl

   task automatic ioc(input logic [5:0] idx, input logic [7:0] v);
      int ch;
      ch = (idx < 6'h0c) ? ((idx < 6'h0a) ? 0 : idx - 6'h09) : ((idx < 6'h0e) ? 3 : idx - 6'h0a);
      wr(idx, v, `TPUCFG_RESP_OKAY);
      if (idx == 6'h09 || idx == 6'h0d)
      begin
         exp_d[ch / 3] = lvl(v[7:4], exp_d[ch / 3]);
         exp_c[ch / 3] = lvl(v[3:0], exp_c[ch / 3]);
      end
      else
      begin
         exp_b[ch] = lvl(v[7:4], exp_b[ch]);
         exp_a[ch] = lvl(v[3:0], exp_a[ch]);
      end
   endtask : ioc

   function automatic logic [31:0] exp_mode(input int ch, input logic [7:0] d);
      return 32'hc0 | ((ch == 0 || ch == 3) ? {26'h0, d[5:0]} : {28'h0, d[3:0]});
   endfunction : exp_mode

   task automatic count_win(input int n, output int c[3]);
      c = '{0, 0, 0};
      repeat (n)
      begin
         @(posedge aclk);
         for (int j = 0; j < 3; j++)
            c[j] += (tick[j] === 1'b1) ? 1 : 0;
      end
   endtask : count_win

   // main sequence
   initial
   begin
      logic [7:0] d;
      logic [5:0] idx;
      int c[3];
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 16; i++)
         if (i < 6 || i > 7)
            rd_chk(6'(i), (i < 6) ? 32'hc0 : 32'h0, `TPUCFG_RESP_OKAY);
      chk_val({28'h0, gen_c, gen_d}, 32'hf);
      // byte lane 0 off: the write is answered but nothing is stored
      wstrb <= 4'he;
      wr(6'h08, 8'h55, `TPUCFG_RESP_OKAY);
      wstrb <= 4'hf;
      rd_chk(6'h08, 32'h0, `TPUCFG_RESP_OKAY);
      rd_chk(6'h06, 32'h0, `TPUCFG_RESP_SLVERR);
      wr(6'h07, 8'hff, `TPUCFG_RESP_SLVERR);
      chk_pins();
      // random io control values over all eight registers, counters stopped
      for (int k = 0; k < 24; k++)
      begin
         idx = 6'(8 + k % 8);
         d = (k < 8) ? 8'h44 : 8'($random(seed));
         ioc(idx, d);
         rd_chk(idx, {24'h0, d}, `TPUCFG_RESP_OKAY);
         repeat (3) @(posedge aclk);
         chk_pins();
      end
      // random mode values; software keeps bit 3 clear, and bit 2 on channels 0 and 3
      for (int k = 0; k < 18; k++)
      begin
         d = 8'($random(seed));
         d[3] = 1'b0;
         if (k % 6 == 0 || k % 6 == 3)
            d[2] = 1'b0;
         wr(6'(k % 6), d, `TPUCFG_RESP_OKAY);
         rd_chk(6'(k % 6), exp_mode(k % 6, d), `TPUCFG_RESP_OKAY);
      end
      for (int k = 0; k < 6; k++)
         wr(6'(k), (k % 3 == 0) ? 8'h30 : 8'h00, `TPUCFG_RESP_OKAY);
      // buffered c and d: io control writes must not move their pins
      wr(6'h09, 8'h55, `TPUCFG_RESP_OKAY);
      wr(6'h0d, 8'h66, `TPUCFG_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk_val({28'h0, gen_c, gen_d}, 32'h0);
      chk_pins();
      count_win(256, c);
      chk_cnt(c[0] + c[1] + c[2], 0);
      // every clock code on channels 3..5 at once, window a multiple of every period
      wr(6'h14, 8'h38, `TPUCFG_RESP_OKAY);
      for (int code = 0; code < 8; code++)
      begin
         for (int j = 0; j < 3; j++)
            wr(6'(16 + j), 8'(code), `TPUCFG_RESP_OKAY);
         repeat (64) @(posedge aclk);
         count_win(4096, c);
         chk_cnt(c[0], 4096 / p3[code]);
         chk_cnt(c[1], 4096 / p4[code]);
         chk_cnt(c[2], 4096 / p5[code]);
      end
      // every mode code on channels 4 and 5; modes only change while stopped
      for (int m = 0; m < 8; m++)
      begin
         wr(6'h14, 8'h00, `TPUCFG_RESP_OKAY);
         wr(6'h04, 8'(m), `TPUCFG_RESP_OKAY);
         wr(6'h05, 8'(m), `TPUCFG_RESP_OKAY);
         wr(6'h14, 8'h30, `TPUCFG_RESP_OKAY);
         repeat (64) @(posedge aclk);
         count_win(4096, c);
         chk_cnt(c[1], m[2] ? 64 : 128);
         chk_cnt(c[2], m[2] ? 16 : 128);
         chk_val({28'h0, phase[5:4], pwm[5:4]}, {28'h0, {2{m[2]}}, {2{m[2:1] == 2'b01}}});
      end
      // pwm mode 2 on channel 1: levels held while counting, applied at clear
      wr(6'h14, 8'h00, `TPUCFG_RESP_OKAY);
      wr(6'h01, 8'h03, `TPUCFG_RESP_OKAY);
      ioc(6'h0a, 8'h15);
      wr(6'h14, 8'h02, `TPUCFG_RESP_OKAY);
      wr(6'h0a, 8'h51, `TPUCFG_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk_pins();
      chk_val({31'h0, pwm[1]}, 32'h1);
      clr <= 6'h02;
      @(posedge aclk);
      clr <= 6'h00;
      repeat (3) @(posedge aclk);
      exp_a[1] = 1'b0;
      exp_b[1] = 1'b1;
      chk_pins();
      report_and_stop();
   end
endmodule : test_tpucfg_top
